/* File: pkg/osc_cal_regs.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef OSC_CAL_REGS_SVH
`define OSC_CAL_REGS_SVH
`define TUNE_CODE_ADDR      8'h59
`define HOLD_CTRL_ADDR      8'h5c
`define CAL_CTRL_ADDR       8'h5d
`define CAL_STATE_ADDR      8'h5e
`define HOLD_CTRL_RESET     8'h00
`define CAL_CTRL_RESET      8'h40
`define TUNE_CODE_RESET     7'h00
`define TUNE_CODE_MSB       6
`define SETTLE_MSB          6
`define SETTLE_LSB          4
`define CAL_ENABLE_BIT      0
`define HOLD_BIT            0
`define COMPLETE_BIT        0
`define SETTLE_BASE_CYCLES  16'h0010
`endif

/* File: pkg/osc_cal_pkg.sv */
// Types shared by the oscillator calibration control block.
`default_nettype none
package osc_cal_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } reg_rsp_t;

    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_SETTLE,
        CAL_DECIDE,
        CAL_DONE
    } cal_state_t;
endpackage
`default_nettype wire

/* File: logic/osc_cal_engine.sv */
// Successive-approximation search for the oscillator tune code.
`timescale 1ns/1ps
`default_nettype none
`include "osc_cal_regs.svh"
module osc_cal_engine
    import osc_cal_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_start,
    input  wire logic       i_abort,
    input  wire logic [2:0] i_settle_sel,
    input  wire logic       i_freq_high,
    output logic            o_busy,
    output logic            o_done,
    output logic [6:0]      o_code
);
    cal_state_t  state_reg,  state_next;
    logic [6:0]  code_reg,   code_next;
    logic [6:0]  bit_reg,    bit_next;
    logic [15:0] wait_reg,   wait_next;

    // Settle time doubles with each step of the select field.
    function automatic logic [15:0] settle_cycles(input logic [2:0] sel);
        settle_cycles = 16'(`SETTLE_BASE_CYCLES << sel);
    endfunction

    always_comb
    begin
        state_next = state_reg;
        code_next  = code_reg;
        bit_next   = bit_reg;
        wait_next  = wait_reg;
        o_done     = 1'b0;
        if (i_abort)
        begin
            state_next = CAL_IDLE;
        end
        else
        begin
            case (state_reg)
                CAL_IDLE:
                begin
                    if (i_start)
                    begin
                        code_next  = 7'h40;
                        bit_next   = 7'h40;
                        wait_next  = settle_cycles(i_settle_sel);
                        state_next = CAL_SETTLE;
                    end
                end
                CAL_SETTLE:
                begin
                    if (wait_reg == 16'h0000)
                    begin
                        state_next = CAL_DECIDE;
                    end
                    else
                    begin
                        wait_next = wait_reg - 16'h0001;
                    end
                end
                CAL_DECIDE:
                begin
                    // Clear the trial bit when the oscillator runs fast.
                    if (i_freq_high)
                    begin
                        code_next = code_reg & ~bit_reg;
                    end
                    if (bit_reg == 7'h01)
                    begin
                        state_next = CAL_DONE;
                    end
                    else
                    begin
                        bit_next   = bit_reg >> 1;
                        code_next  = (i_freq_high ? (code_reg & ~bit_reg)
                                                  : code_reg) | (bit_reg >> 1);
                        wait_next  = settle_cycles(i_settle_sel);
                        state_next = CAL_SETTLE;
                    end
                end
                CAL_DONE:
                begin
                    // Flagged here, once the last decision is in the code.
                    o_done     = 1'b1;
                    state_next = CAL_IDLE;
                end
                default:
                begin
                    state_next = CAL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_reg <= CAL_IDLE;
            code_reg  <= `TUNE_CODE_RESET;
            bit_reg   <= 7'h00;
            wait_reg  <= 16'h0000;
        end
        else
        begin
            state_reg <= state_next;
            code_reg  <= code_next;
            bit_reg   <= bit_next;
            wait_reg  <= wait_next;
        end
    end

    assign o_busy = (state_reg == CAL_SETTLE) || (state_reg == CAL_DECIDE);
    assign o_code = code_reg;
endmodule
`default_nettype wire

/* File: logic/osc_cal_control.sv */
// Register file and sequencing for oscillator tune calibration.
`timescale 1ns/1ps
`default_nettype none
`include "osc_cal_regs.svh"
module osc_cal_control
    import osc_cal_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire reg_req_t   i_req,
    input  wire logic       i_freq_high,
    output reg_rsp_t        o_rsp,
    output logic [6:0]      o_tune_code,
    output logic            o_pll_hold,
    output logic            o_cal_busy
);
    logic [7:0] hold_reg,     hold_next;
    logic [7:0] ctrl_reg,     ctrl_next;
    logic [6:0] tune_reg,     tune_next;
    logic       complete_reg, complete_next;
    logic       busy_reg,     busy_next;
    reg_rsp_t   rsp_reg,      rsp_next;
    logic       start;
    logic       abort;
    logic       eng_busy;
    logic       eng_done;
    logic [6:0] eng_code;

    function automatic logic hit(input reg_req_t r, input logic [7:0] a);
        hit = r.addr == a;
    endfunction

    wire hold_write = i_req.wr && hit(i_req, `HOLD_CTRL_ADDR);
    wire release_hold = hold_write && hold_reg[`HOLD_BIT]
                        && !i_req.wdata[`HOLD_BIT];

    // Calibration runs only on the hold release with the enable set.
    assign start = release_hold && ctrl_reg[`CAL_ENABLE_BIT];
    assign abort = hold_write && i_req.wdata[`HOLD_BIT];

    osc_cal_engine u_engine (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_start      (start),
        .i_abort      (abort),
        .i_settle_sel (ctrl_reg[`SETTLE_MSB:`SETTLE_LSB]),
        .i_freq_high  (i_freq_high),
        .o_busy       (eng_busy),
        .o_done       (eng_done),
        .o_code       (eng_code)
    );

    always_comb
    begin
        hold_next     = hold_reg;
        ctrl_next     = ctrl_reg;
        tune_next     = tune_reg;
        complete_next = complete_reg;
        busy_next     = (eng_busy && !abort) || start;
        rsp_next      = '0;
        if (hold_write)
        begin
            hold_next = {7'h00, i_req.wdata[`HOLD_BIT]};
        end
        // Control writes land regardless; software keeps them to hold time.
        if (i_req.wr && hit(i_req, `CAL_CTRL_ADDR))
        begin
            ctrl_next = {1'b0, i_req.wdata[`SETTLE_MSB:`SETTLE_LSB], 3'b000,
                         i_req.wdata[`CAL_ENABLE_BIT]};
        end
        if (i_req.wr && hit(i_req, `TUNE_CODE_ADDR))
        begin
            tune_next = i_req.wdata[`TUNE_CODE_MSB:0];
        end
        // The final code arrives in the cycle after the engine leaves busy.
        if (eng_busy || eng_done)
        begin
            tune_next = eng_code;
        end
        // A hold write outranks completion, so the flag never reads 1
        // while the PLL is held.
        if (abort || start)
        begin
            complete_next = 1'b0;
        end
        else if (release_hold || eng_done)
        begin
            complete_next = 1'b1;
        end
        if (i_req.rd)
        begin
            rsp_next.valid = 1'b1;
            case (i_req.addr)
                `HOLD_CTRL_ADDR: rsp_next.rdata = hold_reg;
                `CAL_CTRL_ADDR:  rsp_next.rdata = ctrl_reg;
                `TUNE_CODE_ADDR: rsp_next.rdata = {1'b0, tune_reg};
                `CAL_STATE_ADDR: rsp_next.rdata = {7'h00, complete_reg};
                default:         rsp_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            hold_reg     <= `HOLD_CTRL_RESET;
            ctrl_reg     <= `CAL_CTRL_RESET;
            tune_reg     <= `TUNE_CODE_RESET;
            complete_reg <= 1'b0;
            busy_reg     <= 1'b0;
            rsp_reg      <= '0;
        end
        else
        begin
            hold_reg     <= hold_next;
            ctrl_reg     <= ctrl_next;
            tune_reg     <= tune_next;
            complete_reg <= complete_next;
            busy_reg     <= busy_next;
            rsp_reg      <= rsp_next;
        end
    end

    assign o_rsp       = rsp_reg;
    assign o_tune_code = tune_reg;
    assign o_pll_hold  = hold_reg[`HOLD_BIT];
    assign o_cal_busy  = busy_reg;
endmodule
`default_nettype wire

/* File: verif/osc_cal_control_properties.sv */
// Assertions on the register port and calibration outputs.
`timescale 1ns/1ps
`default_nettype none
`include "osc_cal_regs.svh"
module osc_cal_control_properties
    import osc_cal_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire reg_req_t   i_req,
    input wire logic       i_freq_high,
    input wire reg_rsp_t   o_rsp,
    input wire logic [6:0] o_tune_code,
    input wire logic       o_pll_hold,
    input wire logic       o_cal_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic wr_hold = i_req.wr && i_req.addr == `HOLD_CTRL_ADDR;
    wire logic wr_tune = i_req.wr && i_req.addr == `TUNE_CODE_ADDR;
    wire logic rd_state = i_req.rd && i_req.addr == `CAL_STATE_ADDR;
    wire logic rd_ctrl = i_req.rd && i_req.addr == `CAL_CTRL_ADDR;
    wire logic release_cmd = wr_hold && !i_req.wdata[0];
    a_read_answer: assert property (
        i_req.rd |=> o_rsp.valid)
        else $error("read not answered");
    a_no_stray: assert property (
        !i_req.rd |=> !o_rsp.valid)
        else $error("stray read answer");
    a_hold_write: assert property (
        wr_hold |=> o_pll_hold == $past(i_req.wdata[0]))
        else $error("hold bit not stored");
    a_start_point: assert property (
        $rose(o_cal_busy) |-> $past(release_cmd && o_pll_hold)
        ##1 (o_tune_code == 7'h40))
        else $error("bad calibration start");
    a_hold_aborts: assert property (
        o_pll_hold && $past(o_pll_hold) |-> !o_cal_busy)
        else $error("busy while holding");
    a_tune_stable: assert property (
        !o_cal_busy && !$past(o_cal_busy) && !$past(wr_tune)
        |-> $stable(o_tune_code))
        else $error("tune code moved when idle");
    a_tune_write: assert property (
        wr_tune && !o_cal_busy |=> o_tune_code == $past(i_req.wdata[6:0]))
        else $error("tune write lost");
    a_state_low: assert property (
        rd_state && (o_pll_hold || o_cal_busy) |=> o_rsp.rdata == 8'h00)
        else $error("complete flag set early");
    a_ctrl_reserved: assert property (
        rd_ctrl |=> (o_rsp.rdata & 8'h8e) == 8'h00)
        else $error("reserved control bits set");
    c_start: cover property ($rose(o_cal_busy));
    c_abort: cover property ($fell(o_cal_busy) && o_pll_hold);
    c_state: cover property (rd_state);
endmodule
bind osc_cal_control osc_cal_control_properties chk (.i_clk, .i_rst, .i_req,
    .i_freq_high, .o_rsp, .o_tune_code, .o_pll_hold, .o_cal_busy);
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the oscillator calibration control block.
`timescale 1ns/1ps
`default_nettype none
`include "osc_cal_regs.svh"
module tb_top
    import osc_cal_pkg::*;
;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    reg_req_t   i_req = '0;
    logic       i_freq_high = 1'b0;
    reg_rsp_t   o_rsp;
    logic [6:0] o_tune_code;
    logic       o_pll_hold;
    logic       o_cal_busy;
    int         fails = 0, num_checks = 0, seed = 68, dur, last;
    logic [7:0] hold_m, ctrl_m, tune_m, done_m, target = 8'h00;
    osc_cal_control dut (.i_clk, .i_rst, .i_req, .i_freq_high, .o_rsp,
        .o_tune_code, .o_pll_hold, .o_cal_busy);
    always #50 i_clk = ~i_clk;
    // The oscillator runs high whenever the code is above the target.
    always @(negedge i_clk) i_freq_high <= o_tune_code > target[6:0];
    task automatic check(input logic [8:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] mdl(input logic [7:0] a);
        case (a)
            `TUNE_CODE_ADDR: return tune_m;
            `HOLD_CTRL_ADDR: return hold_m;
            `CAL_CTRL_ADDR: return ctrl_m;
            `CAL_STATE_ADDR: return done_m;
            default: return 8'h00;
        endcase
    endfunction
    task automatic wr(input logic [7:0] a, d);
        @(negedge i_clk);
        i_req = '{1'b1, 1'b0, a, d};
        @(negedge i_clk);
        i_req = '0;
        if (a == `HOLD_CTRL_ADDR)
            done_m = d[0] ? 8'h00 : (hold_m[0] ? {7'h00, ~ctrl_m[0]} : done_m);
        if (a == `HOLD_CTRL_ADDR)
            hold_m = d & 8'h01;
        if (a == `CAL_CTRL_ADDR)
            ctrl_m = d & 8'h71;
        if (a == `TUNE_CODE_ADDR)
            tune_m = d & 8'h7f;
    endtask
    task automatic rd(input logic [7:0] a);
        repeat (2) @(negedge i_clk);
        i_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge i_clk);
        i_req = '0;
        check({o_rsp.valid, o_rsp.rdata}, {1'b1, mdl(a)});
    endtask
    task automatic cal(input logic [2:0] st);
        target = 8'($random(seed)) & 8'h7f;
        wr(`HOLD_CTRL_ADDR, 8'h01);
        rd(`CAL_STATE_ADDR);
        wr(`CAL_CTRL_ADDR, {1'b0, st, 4'h1});
        wr(`HOLD_CTRL_ADDR, 8'h00);
        rd(`CAL_STATE_ADDR);
        check({8'h00, o_cal_busy}, 9'h001);
        dur = 0;
        while (o_cal_busy !== 1'b0 && dur < 20000)
        begin
            @(negedge i_clk);
            dur++;
        end
        check({8'h00, dur < 20000}, 9'h001);
        done_m = 8'h01;
        tune_m = target;
        rd(`CAL_STATE_ADDR);
        rd(`TUNE_CODE_ADDR);
        if (st != 3'h0)
            check({8'h00, dur > last}, 9'h001);
        last = dur;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #5_000_000;
        fails++;
        end_of_test();
    end
    initial
    begin
        hold_m = `HOLD_CTRL_RESET;
        ctrl_m = `CAL_CTRL_RESET;
        tune_m = 8'h00;
        done_m = 8'h00;
        repeat (6) @(posedge i_clk);
        @(negedge i_clk) i_rst = 1'b0;
        rd(`HOLD_CTRL_ADDR);
        rd(`CAL_CTRL_ADDR);
        rd(`CAL_STATE_ADDR);
        rd(8'h00);
        $display("test reset done");
        wr(`HOLD_CTRL_ADDR, 8'h01);
        wr(`CAL_CTRL_ADDR, 8'h00);
        wr(`HOLD_CTRL_ADDR, 8'h00);
        rd(`CAL_STATE_ADDR);
        $display("test skip done");
        for (int s = 0; s < 3; s++)
            cal(s[2:0]);
        repeat (4) cal(3'h0);
        $display("test search done");
        wr(`HOLD_CTRL_ADDR, 8'h01);
        wr(`CAL_CTRL_ADDR, 8'h71);
        rd(`CAL_CTRL_ADDR);
        wr(`HOLD_CTRL_ADDR, 8'h00);
        repeat (20) @(negedge i_clk);
        wr(`HOLD_CTRL_ADDR, 8'h01);
        rd(`CAL_STATE_ADDR);
        check({8'h00, o_cal_busy}, 9'h000);
        wr(`CAL_CTRL_ADDR, 8'h70);
        wr(`TUNE_CODE_ADDR, {1'b0, target[6:0]});
        rd(`TUNE_CODE_ADDR);
        wr(`HOLD_CTRL_ADDR, 8'h00);
        rd(`CAL_STATE_ADDR);
        rd(`TUNE_CODE_ADDR);
        $display("test abort done");
        end_of_test();
    end
endmodule
`default_nettype wire
